//--- logic/sspc_unit.sv
// Shadow stack pointer register and push / pop-check execution
// Function
// - Unclaimed maybe-op encodings keep their ordinary behaviour.
// - Pointer is a user read-write register at address 0x011.
// - No upper half; pointer is full word width of the mode.
// - Bits 1:0 read zero; bit 2 zero when width never 32.
// - Enabled push stores at pointer minus word bytes, then decrements.
// - Push decrement commits only after a fault-free store.
// - Push is a normal store based at pointer, full width.
// - Push recognised only with x1 or x5 as second source.
// - Compressed slot one push equals full push of x1.
// - Pop-check reads word at pointer then raises it by word bytes.
// - Pop-check recognised only with x1 or x5 as first source.
// - Compressed slot five pop-check equals full pop-check of x5.
// - Pop-check read is a normal load based at pointer, full width.
// - Mismatch raises software-check cause 18, trap value 3.
// - Access fault outranks the mismatch exception.
// - Pop increment commits only on good load without mismatch.
// - Ordinary stores to shadow pages fault, possibly late.
// - Forwarding from ordinary stores into pop-check may be blocked.
// - Inactive feature leaves these encodings as plain maybe-ops.
// - Enable is independent for user and supervisor; machine mode never runs it.
`timescale 1ns/1ps
`default_nettype none
`include "sspc_consts.svh"
module sspc_unit #(
  parameter int REGISTER_WORD_WIDTH       = 64,
  parameter bit NEVER_32   = 1'b1
) (
  input  wire logic                        i_mclk,
  input  wire logic                        i_srst,
  // Per-mode enables: 0 user, 1 supervisor, 2 machine (unsupported, ignored)
  input  wire logic [2:0]                  i_mode_shadow_stack_enable,
  input  wire logic [1:0]                  i_priv_mode,
  input  wire logic                        i_wide_mode,
  // Issue port
  input  wire logic                        i_issue_valid,
  output logic                             o_issue_ready,
  input  wire logic [31:0]                 i_instr,
  input  wire logic [REGISTER_WORD_WIDTH-1:0]             i_src_value,
  output logic                             o_is_shadow_op,
  output logic [4:0]                       o_src_reg,
  // Load/store path
  output logic                             o_mem_req,
  output logic                             o_mem_we,
  output logic [REGISTER_WORD_WIDTH-1:0]                  o_mem_addr,
  output logic [REGISTER_WORD_WIDTH-1:0]                  o_mem_wdata,
  output logic                             o_mem_no_fwd,
  input  wire logic                        i_mem_gnt,
  input  wire logic                        i_mem_done,
  input  wire logic                        i_mem_fault,
  input  wire logic [7:0]                  i_mem_fault_cause,
  input  wire logic [REGISTER_WORD_WIDTH-1:0]             i_mem_rdata,
  // Completion
  output logic                             o_done,
  output logic                             o_exc,
  output logic [7:0]                       o_exc_cause,
  output logic [7:0]                       o_exc_tval,
  // Register access port
  input  wire logic                        i_csr_we,
  input  wire logic [`SSPC_CSR_ADDR_W-1:0] i_csr_addr,
  input  wire logic [REGISTER_WORD_WIDTH-1:0]             i_csr_wdata,
  output logic [REGISTER_WORD_WIDTH-1:0]                  o_csr_rdata,
  output logic                             o_csr_hit
);
  localparam logic [REGISTER_WORD_WIDTH-1:0] STEP_WIDE   = REGISTER_WORD_WIDTH'(REGISTER_WORD_WIDTH / 8);
  localparam logic [REGISTER_WORD_WIDTH-1:0] STEP_NARROW = REGISTER_WORD_WIDTH'(4);

  sspc_pkg::state_t state;
  sspc_pkg::op_t    op;
  sspc_pkg::op_t    dec_op;
  logic [REGISTER_WORD_WIDTH-1:0]  shadow_stack_pointer;
  logic [REGISTER_WORD_WIDTH-1:0]  check_value;
  logic [4:0]       dec_src;
  logic             exc;
  logic [7:0]       exc_cause;
  logic [7:0]       exc_tval;
  logic             req_pending;

  // Per-mode gate; machine mode never runs the feature
  wire mode_en = (i_priv_mode == 2'b00) ? i_mode_shadow_stack_enable[0] :
                 (i_priv_mode == 2'b01) ? i_mode_shadow_stack_enable[1] : 1'b0;

  sspc_decode u_decode (
    .i_instr  (i_instr),
    .i_enable (mode_en),
    .o_op     (dec_op),
    .o_src    (dec_src)
  );

  // Word size follows the mode width; a never-32 build stays wide, else bit 2 would be lost
  wire            wide = NEVER_32 || i_wide_mode;
  wire [REGISTER_WORD_WIDTH-1:0] step = wide ? STEP_WIDE : STEP_NARROW;

  // Low bits forced to zero; bit 2 also when narrow width impossible
  wire [REGISTER_WORD_WIDTH-1:0] low_mask = NEVER_32 ? {{(REGISTER_WORD_WIDTH-3){1'b1}}, 3'b000}
                                      : {{(REGISTER_WORD_WIDTH-2){1'b1}}, 2'b00};
  wire [REGISTER_WORD_WIDTH-1:0] mode_mask = wide ? {REGISTER_WORD_WIDTH{1'b1}}
                                   : {{(REGISTER_WORD_WIDTH-32){1'b0}}, {32{1'b1}}};

  wire csr_sel   = (i_csr_addr == `SSPC_CSR_ADDR);
  wire csr_write = i_csr_we && csr_sel && (state == sspc_pkg::ST_IDLE);

  wire start     = i_issue_valid && (state == sspc_pkg::ST_IDLE)
                 && (dec_op != sspc_pkg::OP_NONE);
  wire [REGISTER_WORD_WIDTH-1:0] push_addr = (shadow_stack_pointer - step) & mode_mask;
  wire [REGISTER_WORD_WIDTH-1:0] pop_addr  = shadow_stack_pointer & mode_mask;

  wire fin       = (state == sspc_pkg::ST_MEM) && i_mem_done;
  wire mismatch  = (op == sspc_pkg::OP_POP)
                 && ((i_mem_rdata & mode_mask) != (check_value & mode_mask));
  // Access fault reported first; check only on a clean load
  wire good      = fin && !i_mem_fault && !mismatch;

  wire [REGISTER_WORD_WIDTH-1:0] next_ssp =
      csr_write ? (i_csr_wdata & low_mask & mode_mask) :
      (good && op == sspc_pkg::OP_PUSH) ? push_addr :
      (good && op == sspc_pkg::OP_POP)  ? ((pop_addr + step) & mode_mask) :
      shadow_stack_pointer;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      shadow_stack_pointer <= REGISTER_WORD_WIDTH'(`SSPC_SSP_RESET);
    end else begin
      shadow_stack_pointer <= next_ssp & low_mask;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state       <= sspc_pkg::ST_IDLE;
      op          <= sspc_pkg::OP_NONE;
      req_pending <= 1'b0;
      o_mem_we    <= 1'b0;
      o_mem_addr  <= '0;
      o_mem_wdata <= '0;
      check_value <= '0;
    end else begin
      unique case (state)
        sspc_pkg::ST_IDLE: begin
          if (start) begin
            state       <= sspc_pkg::ST_MEM;
            op          <= dec_op;
            req_pending <= 1'b1;
            o_mem_we    <= (dec_op == sspc_pkg::OP_PUSH);
            o_mem_addr  <= (dec_op == sspc_pkg::OP_PUSH) ? push_addr : pop_addr;
            o_mem_wdata <= i_src_value & mode_mask;
            check_value <= i_src_value;
          end
        end
        sspc_pkg::ST_MEM: begin
          if (i_mem_gnt) begin
            req_pending <= 1'b0;
          end
          if (i_mem_done) begin
            state       <= sspc_pkg::ST_DONE;
            req_pending <= 1'b0;
          end
        end
        sspc_pkg::ST_DONE: begin
          state <= sspc_pkg::ST_IDLE;
          op    <= sspc_pkg::OP_NONE;
        end
        default: begin
          state <= sspc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Exception result captured at completion
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      exc       <= 1'b0;
      exc_cause <= 8'h00;
      exc_tval  <= 8'h00;
    end else if (fin) begin
      exc       <= i_mem_fault || mismatch;
      exc_cause <= i_mem_fault ? i_mem_fault_cause : `SSPC_CAUSE_SWCHECK;
      exc_tval  <= i_mem_fault ? 8'h00 : `SSPC_TVAL_SS_FAULT;
    end
  end

  // Late page checks live in the translation path; loads from pop-check
  // ask the store queue not to forward from ordinary stores
  assign o_mem_no_fwd   = (op == sspc_pkg::OP_POP);
  assign o_mem_req      = req_pending && (state == sspc_pkg::ST_MEM);
  assign o_issue_ready  = (state == sspc_pkg::ST_IDLE);
  assign o_is_shadow_op = (dec_op != sspc_pkg::OP_NONE);
  assign o_src_reg      = dec_src;
  assign o_done         = (state == sspc_pkg::ST_DONE);
  assign o_exc          = o_done && exc;
  assign o_exc_cause    = exc_cause;
  assign o_exc_tval     = exc_tval;
  assign o_csr_hit      = csr_sel;
  assign o_csr_rdata    = csr_sel ? (shadow_stack_pointer & mode_mask) : '0;
endmodule : sspc_unit
`default_nettype wire

//--- inc/sspc_consts.svh
// Constants for the shadow stack push / pop-check unit
`ifndef SSPC_CONSTS_SVH
`define SSPC_CONSTS_SVH
`define SSPC_CSR_ADDR          12'h011
`define SSPC_CSR_ADDR_W        12
`define SSPC_OPC_SYSTEM        7'h73
`define SSPC_FUNCT3_MOP        3'h4
`define SSPC_PUSH_FUNCT7       7'h67
`define SSPC_POP_FUNCT12       12'hcdc
`define SSPC_C_QUAD1           2'h1
`define SSPC_C_FUNCT3          3'h3
`define SSPC_C_PUSH_N          3'h0
`define SSPC_C_POP_N           3'h2
`define SSPC_REG_RA            5'h01
`define SSPC_REG_T0            5'h05
`define SSPC_CAUSE_SWCHECK     8'h12
`define SSPC_TVAL_SS_FAULT     8'h03
`define SSPC_SSP_RESET         64'h0
`endif

//--- inc/sspc_pkg.sv
// Types for the shadow stack push / pop-check unit
package sspc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MEM  = 2'b01,
    ST_DONE = 2'b10
  } state_t;
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_PUSH = 2'b01,
    OP_POP  = 2'b10
  } op_t;
endpackage : sspc_pkg

//--- logic/sspc_decode.sv
// Instruction decoder for shadow stack push and pop-check
`timescale 1ns/1ps
`default_nettype none
`include "sspc_consts.svh"
module sspc_decode (
  input  wire logic [31:0] i_instr,
  input  wire logic        i_enable,
  output sspc_pkg::op_t    o_op,
  output logic [4:0]       o_src
);
  wire [6:0]  opc    = i_instr[6:0];
  wire [4:0]  rd     = i_instr[11:7];
  wire [2:0]  funct3 = i_instr[14:12];
  wire [4:0]  rs1    = i_instr[19:15];
  wire [4:0]  rs2    = i_instr[24:20];
  wire [15:0] ci     = i_instr[15:0];
  wire        is_32  = (i_instr[1:0] == 2'b11);
  wire        sys_mop = is_32 && (opc == `SSPC_OPC_SYSTEM) && (funct3 == `SSPC_FUNCT3_MOP)
                      && (rd == 5'h00);
  wire        link_rs2 = (rs2 == `SSPC_REG_RA) || (rs2 == `SSPC_REG_T0);
  wire        link_rs1 = (rs1 == `SSPC_REG_RA) || (rs1 == `SSPC_REG_T0);
  wire        push32 = sys_mop && (i_instr[31:25] == `SSPC_PUSH_FUNCT7)
                     && (rs1 == 5'h00) && link_rs2;
  wire        pop32  = sys_mop && (i_instr[31:20] == `SSPC_POP_FUNCT12)
                     && link_rs1;
  wire        cmop   = !is_32 && (ci[1:0] == `SSPC_C_QUAD1) && (ci[15:13] == `SSPC_C_FUNCT3)
                     && (ci[12:11] == 2'b00) && ci[7] && (ci[6:2] == 5'h00);
  wire        cpush  = cmop && (ci[10:8] == `SSPC_C_PUSH_N);
  wire        cpop   = cmop && (ci[10:8] == `SSPC_C_POP_N);
  // Disabled mode leaves every encoding as its plain maybe-op
  wire        is_push = i_enable && (push32 || cpush);
  wire        is_pop  = i_enable && (pop32 || cpop);
  assign o_op  = is_push ? sspc_pkg::OP_PUSH : (is_pop ? sspc_pkg::OP_POP : sspc_pkg::OP_NONE);
  assign o_src = cpush ? `SSPC_REG_RA : (cpop ? `SSPC_REG_T0 : (push32 ? rs2 : rs1));
endmodule : sspc_decode
`default_nettype wire

//--- tb/sspc_unit_monitor.sv
// Assertion checker bound to the shadow stack unit
`timescale 1ns/1ps
`default_nettype none
module sspc_unit_monitor #(parameter int REGISTER_WORD_WIDTH = 64) (
  input wire logic            i_mclk, i_srst, i_wide_mode, i_mem_gnt, i_mem_done, i_mem_fault,
  input wire logic            o_mem_req, o_mem_we, o_mem_no_fwd, o_done, o_exc, o_csr_hit,
  input wire logic            o_is_shadow_op,
  input wire logic [1:0]      i_priv_mode,
  input wire logic [2:0]      i_mode_shadow_stack_enable,
  input wire logic [7:0]      i_mem_fault_cause, o_exc_cause, o_exc_tval,
  input wire logic [11:0]     i_csr_addr,
  input wire logic [REGISTER_WORD_WIDTH-1:0] i_src_value, i_mem_rdata, o_mem_addr, o_csr_rdata
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // Pointer is only visible while the read port points at it
  wire sel = i_csr_addr == 12'h011 && i_wide_mode;
  a_push_addr: assert property ($rose(o_mem_req) && o_mem_we && sel
    |-> o_mem_addr == o_csr_rdata - 8) else $error("push address wrong");
  a_pop_addr: assert property ($rose(o_mem_req) && !o_mem_we && sel
    |-> o_mem_addr == o_csr_rdata && o_mem_no_fwd) else $error("pop access wrong");
  a_push_commit: assert property ($past(i_mem_done && o_mem_we && !i_mem_fault) && sel
    |-> o_csr_rdata == $past(o_mem_addr)) else $error("push pointer not committed");
  a_mismatch_trap: assert property ($past(i_mem_done && !i_mem_fault && !o_mem_we
    && i_mem_rdata != i_src_value) |-> o_exc && o_exc_cause == 8'h12 && o_exc_tval == 8'h03)
    else $error("mismatch trap wrong");
  a_fault_first: assert property ($past(i_mem_done && i_mem_fault)
    |-> o_exc && o_exc_cause == $past(i_mem_fault_cause)) else $error("fault cause wrong");
  a_trap_keeps_ptr: assert property (o_done && o_exc && sel |-> $stable(o_csr_rdata))
    else $error("pointer moved on trap");
  a_low_bits_zero: assert property (o_csr_hit |-> o_csr_rdata[2:0] == 3'h0)
    else $error("low pointer bits set");
  a_req_holds: assert property (o_mem_req && !i_mem_gnt |=> o_mem_req && $stable(o_mem_addr))
    else $error("request dropped early");
  a_done_bound: assert property ($rose(o_mem_req) |-> ##[1:40] o_done)
    else $error("no completion");
  a_mode_gate: assert property (i_priv_mode == 2'h0 && !i_mode_shadow_stack_enable[0]
    |-> !o_is_shadow_op) else $error("decode while disabled");
endmodule : sspc_unit_monitor
`default_nettype wire

//--- tb/sspc_mem_model.sv
// Load/store path model with one stored word and a set delay
`timescale 1ns/1ps
`default_nettype none
module sspc_mem_model (
  input wire logic        i_mclk, i_srst, i_req, i_we, i_fault,
  input wire logic [3:0]  i_delay,
  input wire logic [63:0] i_wdata, i_flip,
  output logic            o_gnt, o_done, o_fault,
  output logic [63:0]     o_rdata
);
  logic        busy;
  logic [3:0]  cnt;
  logic [63:0] word;
  always_ff @(posedge i_mclk) begin
    o_gnt <= 1'b0;
    o_done <= 1'b0;
    o_fault <= 1'b0;
    // Stale data toggles so it never passes for a valid answer
    o_rdata <= ~o_rdata;
    if (i_srst) begin
      busy <= 1'b0;
      o_rdata <= 64'h0;
    end else if (i_req && !busy) begin
      o_gnt <= 1'b1;
      busy <= 1'b1;
      cnt <= i_delay;
    end else if (busy && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (busy) begin
      busy <= 1'b0;
      o_done <= 1'b1;
      o_fault <= i_fault;
      o_rdata <= word ^ i_flip;
      if (i_we && !i_fault) word <= i_wdata;
    end
  end
endmodule : sspc_mem_model
`default_nettype wire

//--- tb/sspc_unit_bench.sv
// Self-checking bench for the shadow stack unit
`timescale 1ns/1ps
`default_nettype none
module sspc_unit_bench;
  logic        i_mclk = 0, i_srst = 1, i_wide_mode = 1, i_issue_valid = 0, i_csr_we = 0;
  logic        i_mem_gnt, i_mem_done, i_mem_fault, o_issue_ready, o_is_shadow_op, o_mem_req;
  logic        o_mem_we, o_mem_no_fwd, o_done, o_exc, o_csr_hit, flt = 0, mwe, nofwd;
  logic [1:0]  i_priv_mode = 2'h0;
  logic [2:0]  i_mode_shadow_stack_enable = 3'h3;
  logic [3:0]  dly = 4'h0;
  logic [4:0]  o_src_reg;
  logic [7:0]  i_mem_fault_cause = 8'h05, o_exc_cause, o_exc_tval;
  logic [11:0] i_csr_addr = 12'h011;
  logic [31:0] i_instr = 32'h0;
  logic [63:0] i_src_value = 0, i_csr_wdata = 0, i_mem_rdata, o_mem_addr, o_mem_wdata;
  logic [63:0] o_csr_rdata, flip = 0, ma, mw, p;
  int          fail_count = 0, samples_checked = 0, cyc = 0;
  always #4 i_mclk = ~i_mclk;
  sspc_unit i_dut (
    .i_mclk                     (i_mclk),
    .i_srst                     (i_srst),
    .i_mode_shadow_stack_enable (i_mode_shadow_stack_enable),
    .i_priv_mode                (i_priv_mode),
    .i_wide_mode                (i_wide_mode),
    .i_issue_valid              (i_issue_valid),
    .o_issue_ready              (o_issue_ready),
    .i_instr                    (i_instr),
    .i_src_value                (i_src_value),
    .o_is_shadow_op             (o_is_shadow_op),
    .o_src_reg                  (o_src_reg),
    .o_mem_req                  (o_mem_req),
    .o_mem_we                   (o_mem_we),
    .o_mem_addr                 (o_mem_addr),
    .o_mem_wdata                (o_mem_wdata),
    .o_mem_no_fwd               (o_mem_no_fwd),
    .i_mem_gnt                  (i_mem_gnt),
    .i_mem_done                 (i_mem_done),
    .i_mem_fault                (i_mem_fault),
    .i_mem_fault_cause          (i_mem_fault_cause),
    .i_mem_rdata                (i_mem_rdata),
    .o_done                     (o_done),
    .o_exc                      (o_exc),
    .o_exc_cause                (o_exc_cause),
    .o_exc_tval                 (o_exc_tval),
    .i_csr_we                   (i_csr_we),
    .i_csr_addr                 (i_csr_addr),
    .i_csr_wdata                (i_csr_wdata),
    .o_csr_rdata                (o_csr_rdata),
    .o_csr_hit                  (o_csr_hit)
  );
  sspc_mem_model i_mem (.i_mclk(i_mclk), .i_srst(i_srst), .i_req(o_mem_req), .i_we(o_mem_we),
    .i_fault(flt), .i_delay(dly), .i_wdata(o_mem_wdata), .i_flip(flip), .o_gnt(i_mem_gnt),
    .o_done(i_mem_done), .o_fault(i_mem_fault), .o_rdata(i_mem_rdata));
  task chk(input logic [63:0] s, e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task give_verdict;
    $display("fail_count=%0d samples_checked=%0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      give_verdict;
    end
  end
  function automatic logic [31:0] push(input logic [4:0] r);
    return {7'h67, r, 5'h00, 3'h4, 5'h00, 7'h73};
  endfunction : push
  function automatic logic [31:0] pop(input logic [4:0] r);
    return {12'hcdc, r, 3'h4, 5'h00, 7'h73};
  endfunction : pop
  // Offer one instruction; r is the expected source, zero if not claimed
  task run(input logic [31:0] ins, input logic [4:0] r, input logic [63:0] s);
    int n;
    @(negedge i_mclk);
    i_instr = ins;
    i_src_value = s;
    i_issue_valid = 1;
    #1 chk(o_is_shadow_op, r != 0);
    if (r != 0) chk(o_src_reg, r);
    @(negedge i_mclk);
    i_issue_valid = 0;
    n = 0;
    while (r != 0 && o_done !== 1'b1 && n < 50) begin
      if (o_mem_req) {ma, mw, mwe, nofwd} = {o_mem_addr, o_mem_wdata, o_mem_we, o_mem_no_fwd};
      @(negedge i_mclk);
      n++;
    end
    chk(n < 50, 1);
  endtask : run
  task pchk(input logic [31:0] ins, input logic [4:0] r, input logic [63:0] s, input logic f);
    flt = f;
    run(ins, r, s);
    chk(ma, p - 64'h8);
    chk(mw, s);
    chk(mwe, 1'b1);
    chk(o_exc, f);
    if (!f) p = p - 64'h8;
    chk(o_csr_rdata, p);
  endtask : pchk
  task popchk(input logic [31:0] ins, input logic [4:0] r, input logic f, input logic [63:0] fl);
    flt = f;
    flip = fl;
    run(ins, r, 64'hc3);
    chk(ma, p);
    chk({mwe, nofwd}, 2'b01);
    chk(o_exc, f | (fl != 0));
    if (f | (fl != 0)) chk({o_exc_cause, o_exc_tval}, f ? 16'h0500 : 16'h1203);
    else p = p + 64'h8;
    chk(o_csr_rdata, p);
    flip = 0;
  endtask : popchk
  task csr(input logic [11:0] a, input logic [63:0] w, e);
    @(negedge i_mclk);
    {i_csr_addr, i_csr_wdata, i_csr_we} = {a, w, 1'b1};
    @(negedge i_mclk);
    i_csr_we = 0;
    #1 chk(o_csr_rdata, e);
    chk(o_csr_hit, a == 12'h011);
    i_csr_addr = 12'h011;
  endtask : csr
  task sc_reg;
    chk(o_csr_rdata, 64'h0);
    chk(o_issue_ready, 1'b1);
    csr(12'h011, 64'h8000_0000_0000_100f, 64'h8000_0000_0000_1008);
    csr(12'h012, 64'h0, 64'h0);
    p = 64'h8000_0000_0000_1008;
    #1 chk(o_csr_rdata, p);
  endtask : sc_reg
  task sc_push;
    pchk(push(5'h01), 5'h01, 64'ha1, 0);
    pchk(32'h6081, 5'h01, 64'hb2, 0);
    dly = 4'h5;
    pchk(push(5'h05), 5'h05, 64'hc3, 0);
    pchk(push(5'h05), 5'h05, 64'hd4, 1);
    dly = 4'h0;
  endtask : sc_push
  task sc_pop;
    popchk(32'h6281, 5'h05, 0, 0);
    popchk(pop(5'h01), 5'h01, 0, 64'h1);
    popchk(pop(5'h05), 5'h05, 1, 64'h1);
    // Never-32 build keeps full width and step with the narrow flag low
    i_wide_mode = 0;
    popchk(pop(5'h01), 5'h01, 0, 64'h0);
    i_wide_mode = 1;
  endtask : sc_pop
  task sc_decode;
    run(push(5'h03), 5'h00, 64'h0);
    run(pop(5'h03), 5'h00, 64'h0);
    run(push(5'h01) | 32'h80, 5'h00, 64'h0);
    i_mode_shadow_stack_enable = 3'h2;
    run(push(5'h01), 5'h00, 64'h0);
    i_priv_mode = 2'h1;
    pchk(push(5'h01), 5'h01, 64'he5, 0);
    i_mode_shadow_stack_enable = 3'h5;
    run(pop(5'h01), 5'h00, 64'h0);
    i_priv_mode = 2'h3;
    run(push(5'h01), 5'h00, 64'h0);
  endtask : sc_decode
  initial begin
    repeat (5) @(negedge i_mclk);
    i_srst = 0;
    sc_reg;
    sc_push;
    sc_pop;
    sc_decode;
    give_verdict;
  end
endmodule : sspc_unit_bench
bind sspc_unit sspc_unit_monitor #(.REGISTER_WORD_WIDTH(REGISTER_WORD_WIDTH)) i_mon (
  .i_mclk(i_mclk), .i_srst(i_srst), .i_wide_mode(i_wide_mode), .i_mem_gnt(i_mem_gnt),
  .i_mem_done(i_mem_done), .i_mem_fault(i_mem_fault), .o_mem_req(o_mem_req),
  .o_mem_we(o_mem_we), .o_mem_no_fwd(o_mem_no_fwd), .o_done(o_done), .o_exc(o_exc),
  .o_csr_hit(o_csr_hit), .o_is_shadow_op(o_is_shadow_op), .i_priv_mode(i_priv_mode),
  .i_mode_shadow_stack_enable(i_mode_shadow_stack_enable),
  .i_mem_fault_cause(i_mem_fault_cause), .o_exc_cause(o_exc_cause), .o_exc_tval(o_exc_tval),
  .i_csr_addr(i_csr_addr), .i_src_value(i_src_value), .i_mem_rdata(i_mem_rdata),
  .o_mem_addr(o_mem_addr), .o_csr_rdata(o_csr_rdata)
);
`default_nettype wire
